// >>> rtl/qcs_consts.vh
// Constants for the per-port classifier, rate limiter and scheduler
`ifndef QCS_CONSTS_VH
`define QCS_CONSTS_VH
// Register byte addresses
`define QCS_A_CTRL 8'h00
`define QCS_A_DEFPRI 8'h04
`define QCS_A_ING_RATE 8'h08
`define QCS_A_COMMITTED_RATE 8'h0c
`define QCS_A_BURST 8'h10
`define QCS_A_LINE_RATE 8'h14
`define QCS_A_STATUS 8'h18
`define QCS_A_DROPS 8'h1c
`define QCS_A_PRI_MAP 8'h20
`define QCS_A_DSCP_MAP 8'h24
// Control bits
`define QCS_C_QOS_EN 0
`define QCS_C_TRUST_DSCP 1
`define QCS_C_ING_EN 2
`define QCS_C_EGR_EN 3
`define QCS_C_RESTORE_PRI 8
`define QCS_C_RESTORE_DSCP 9
// Status bits
`define QCS_S_REJECT 0
`define QCS_S_ING_OK 1
`define QCS_S_EGR_OK 2
// Map entry write fields
`define QCS_F_QUEUE_HI 9
`define QCS_F_QUEUE_LO 8
// Priorities and queues (queue code 0..3 stands for queue 1..4)
`define QCS_PRIO_STRICT_MIN 3'd6
`define QCS_Q_BEST_EFFORT 2'd0
`define QCS_Q_STRICT 2'd3
`define QCS_W_Q1 4'd1
`define QCS_W_Q2 4'd2
`define QCS_W_Q3 4'd10
// Factory priority-to-queue table, entry i at bits [2i+1:2i]
`define QCS_PRI_MAP_DEF 16'hfa50
// Rates in kbit/s, burst in bytes
`define QCS_ING_RATE_MIN 30'd3500
`define QCS_ING_RATE_MAX 30'd1000000
`define QCS_COMMITTED_RATE_MIN 30'd64
`define QCS_COMMITTED_RATE_MAX 30'd1000000000
`define QCS_BURST_MIN 24'd4096
`define QCS_BURST_MAX 24'd16769020
`define QCS_LINE_RATE_DEF 30'd1000000
`define QCS_ING_BURST_BYTES 24'd4096
// Token unit: one bucket count per kbit/s per clock; cost per byte derived from the clock
`define QCS_CLK_HZ 48'd100000000
`define QCS_TOK_PER_BYTE (48'd8 * `QCS_CLK_HZ / 48'd1000)
`define QCS_DROP_MAX 16'hffff
`endif

// >>> rtl/qcs_token_bucket.v
// Token bucket used both for ingress policing and egress shaping
`timescale 1ns/1ns
`include "qcs_consts.vh"
module qcs_token_bucket (
  input wire clk_i,
  input wire rst_b_i,
  input wire ce_i,
  input wire en_i,
  input wire [29:0] rate_i,
  input wire [47:0] cap_i,
  input wire [47:0] cost_i,
  input wire take_i,
  output wire ok_o
);
  reg [47:0] bucket_q;
  reg [48:0] sum;

  // Disabled bucket passes everything and stays full
  assign ok_o = !en_i || (bucket_q >= cost_i);

  always @* begin
    sum = {1'b0, bucket_q} + {19'h0, rate_i};
    if (take_i && ok_o)
      sum = sum - {1'b0, cost_i};
  end

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      bucket_q <= 48'h0;
    end else if (ce_i) begin
      if (!en_i || sum > {1'b0, cap_i})
        bucket_q <= cap_i;
      else
        bucket_q <= sum[47:0];
    end
  end
endmodule

// >>> rtl/qcs_top.v
// Per-port frame classifier, ingress policer, egress shaper and queue scheduler
//
// What this block does
// - Untagged frames take the per-port default priority 0..7 for queue selection.
// - Priorities are ordered, 0 lowest and 7 highest.
// - Priority-to-queue table is rewritable one entry at a time.
// - Four egress queues, 1 lowest, 4 highest.
// - Queue 4 is always served first whenever it holds a frame.
// - Queues 1, 2, 3 share the rest by round robin, weights 1, 2, 10.
// - Mapping priorities 0..5 to queue 4 is rejected.
// - A global enable turns classification and priority queuing on or off.
// - Trust mode picks the VLAN priority field or the DSCP field.
// - In DSCP trust mode, frames lacking the DSCP field go to best effort; untagged frames in VLAN trust mode use the port default.
// - DSCP-to-queue table is writable and has a restore command.
// - Ingress limiter, off after reset, rate 3,500..1,000,000 kbit/s.
// - Egress shaper, off after reset, rate 64..1,000,000,000 kbit/s.
// - Egress burst size 4096..16,769,020 bytes.
// - With several shaping limits the lower one is enforced.
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`include "qcs_consts.vh"
module qcs_top (
  input wire clk_i,
  input wire rst_b_i,
  input wire ce_i,
  input wire [7:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  input wire in_valid_i,
  input wire in_tagged_i,
  input wire [2:0] in_vlan_priority_value_i,
  input wire in_has_dscp_i,
  input wire [5:0] in_dscp_i,
  input wire [13:0] in_len_i,
  output reg in_drop_o,
  output reg enq_valid_o,
  output reg [1:0] enq_queue_o,
  output reg [13:0] enq_len_o,
  input wire [3:0] q_nonempty_i,
  input wire [55:0] q_head_len_i,
  input wire tx_ready_i,
  output reg deq_valid_o,
  output reg [1:0] deq_queue_o
);
  reg qos_global_enable_q;
  reg trust_dscp_q;
  reg ing_en_q;
  reg egr_en_q;
  reg [2:0] port_default_priority_q;
  reg [29:0] ing_rate_q;
  reg [29:0] committed_rate_q;
  reg [23:0] committed_burst_bytes_q;
  reg [29:0] line_rate_q;
  reg reject_q;
  reg [15:0] drops_q;
  reg [15:0] pri_map_q;
  reg [127:0] dscp_map_q;
  reg [5:0] dscp_idx_q;
  reg [2:0] prio;
  reg [1:0] queue;
  reg [31:0] rd_val;
  wire wr_ctrl;
  wire wr_pri;
  wire wr_dscp;
  wire wr_defpri;
  wire wr_ing_rate;
  wire wr_crate;
  wire wr_burst;
  wire wr_line;
  wire wr_status;
  wire wr_drops;
  wire [2:0] map_prio;
  wire [1:0] map_queue;
  wire [5:0] map_dscp;
  wire [47:0] ing_cap;
  wire [47:0] ing_cost;
  wire [47:0] egr_cap;
  wire [47:0] egr_cost;
  wire pri_reject;
  wire ing_ok;
  wire egr_ok;
  wire sel_valid;
  wire [1:0] sel_q;
  wire grant;
  wire [29:0] egr_rate;
  wire [13:0] head_len;
  integer i;

  function [29:0] clamp30;
    input [31:0] v;
    input [29:0] lo;
    input [29:0] hi;
    clamp30 = (v < {2'b00, lo}) ? lo : (v > {2'b00, hi}) ? hi : v[29:0];
  endfunction

  function [47:0] tokens_of;
    input [23:0] bytes;
    tokens_of = {24'h0, bytes} * `QCS_TOK_PER_BYTE;
  endfunction

  function [1:0] pri_to_q;
    input [15:0] map;
    input [2:0] p;
    pri_to_q = map[{p, 1'b0} +: 2];
  endfunction

  // Factory DSCP entries follow the class selector bits
  function [127:0] dscp_default;
    input [15:0] map;
    integer k;
    begin
      dscp_default = 128'h0;
      for (k = 0; k < 64; k = k + 1)
        dscp_default[2*k +: 2] = pri_to_q(map, k[5:3]);
    end
  endfunction

  // One decode per register keeps the write paths readable
  assign wr_ctrl = reg_wr_i && reg_addr_i == `QCS_A_CTRL;
  assign wr_defpri = reg_wr_i && reg_addr_i == `QCS_A_DEFPRI;
  assign wr_ing_rate = reg_wr_i && reg_addr_i == `QCS_A_ING_RATE;
  assign wr_crate = reg_wr_i && reg_addr_i == `QCS_A_COMMITTED_RATE;
  assign wr_burst = reg_wr_i && reg_addr_i == `QCS_A_BURST;
  assign wr_line = reg_wr_i && reg_addr_i == `QCS_A_LINE_RATE;
  assign wr_status = reg_wr_i && reg_addr_i == `QCS_A_STATUS;
  assign wr_drops = reg_wr_i && reg_addr_i == `QCS_A_DROPS;
  assign wr_pri = reg_wr_i && reg_addr_i == `QCS_A_PRI_MAP;
  assign wr_dscp = reg_wr_i && reg_addr_i == `QCS_A_DSCP_MAP;

  // Map entry writes carry the index low and the queue code above it
  assign map_prio = reg_wdata_i[2:0];
  assign map_dscp = reg_wdata_i[5:0];
  assign map_queue = reg_wdata_i[`QCS_F_QUEUE_HI:`QCS_F_QUEUE_LO];

  // Only the two highest priorities may use the strict queue
  assign pri_reject = wr_pri && map_prio < `QCS_PRIO_STRICT_MIN && map_queue == `QCS_Q_STRICT;

  // Configuration registers
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      qos_global_enable_q <= 1'b0;
      trust_dscp_q <= 1'b0;
      ing_en_q <= 1'b0;
      egr_en_q <= 1'b0;
      port_default_priority_q <= 3'd0;
      ing_rate_q <= `QCS_ING_RATE_MAX;
      committed_rate_q <= `QCS_COMMITTED_RATE_MAX;
      committed_burst_bytes_q <= `QCS_BURST_MIN;
      line_rate_q <= `QCS_LINE_RATE_DEF;
      pri_map_q <= `QCS_PRI_MAP_DEF;
      dscp_map_q <= dscp_default(`QCS_PRI_MAP_DEF);
      dscp_idx_q <= 6'd0;
    end else if (ce_i) begin
      if (wr_ctrl) begin
        qos_global_enable_q <= reg_wdata_i[`QCS_C_QOS_EN];
        trust_dscp_q <= reg_wdata_i[`QCS_C_TRUST_DSCP];
        ing_en_q <= reg_wdata_i[`QCS_C_ING_EN];
        egr_en_q <= reg_wdata_i[`QCS_C_EGR_EN];
        // Restore bits act once and are not stored
        if (reg_wdata_i[`QCS_C_RESTORE_PRI])
          pri_map_q <= `QCS_PRI_MAP_DEF;
        if (reg_wdata_i[`QCS_C_RESTORE_DSCP])
          dscp_map_q <= dscp_default(`QCS_PRI_MAP_DEF);
      end
      if (wr_defpri)
        port_default_priority_q <= reg_wdata_i[2:0];
      if (wr_ing_rate)
        ing_rate_q <= clamp30(reg_wdata_i, `QCS_ING_RATE_MIN, `QCS_ING_RATE_MAX);
      if (wr_crate)
        committed_rate_q <= clamp30(reg_wdata_i, `QCS_COMMITTED_RATE_MIN, `QCS_COMMITTED_RATE_MAX);
      if (wr_burst) begin
        if (reg_wdata_i < {8'h0, `QCS_BURST_MIN})
          committed_burst_bytes_q <= `QCS_BURST_MIN;
        else if (reg_wdata_i > {8'h0, `QCS_BURST_MAX})
          committed_burst_bytes_q <= `QCS_BURST_MAX;
        else
          committed_burst_bytes_q <= reg_wdata_i[23:0];
      end
      if (wr_line)
        line_rate_q <= clamp30(reg_wdata_i, `QCS_COMMITTED_RATE_MIN, `QCS_COMMITTED_RATE_MAX);
      // Rejected entries leave the table untouched
      if (wr_pri && !pri_reject)
        pri_map_q[{map_prio, 1'b0} +: 2] <= map_queue;
      if (wr_dscp) begin
        dscp_idx_q <= map_dscp;
        dscp_map_q[{map_dscp, 1'b0} +: 2] <= map_queue;
      end
    end
  end

  // Reject flag: write 1 clears, a new reject in the same cycle wins
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      reject_q <= 1'b0;
    end else if (ce_i) begin
      if (pri_reject)
        reject_q <= 1'b1;
      else if (wr_status && reg_wdata_i[`QCS_S_REJECT])
        reject_q <= 1'b0;
    end
  end

  // Classification
  always @* begin
    prio = port_default_priority_q;
    queue = `QCS_Q_BEST_EFFORT;
    if (!qos_global_enable_q) begin
      queue = `QCS_Q_BEST_EFFORT;
    end else if (trust_dscp_q) begin
      if (in_has_dscp_i)
        queue = dscp_map_q[{in_dscp_i, 1'b0} +: 2];
      else
        queue = `QCS_Q_BEST_EFFORT;
    end else begin
      // Untagged frames keep the port default, not best effort
      if (in_tagged_i)
        prio = in_vlan_priority_value_i;
      queue = pri_to_q(pri_map_q, prio);
    end
  end

  // Bucket limits in token units; the ingress burst is fixed
  assign ing_cap = tokens_of(`QCS_ING_BURST_BYTES);
  assign ing_cost = tokens_of({10'h0, in_len_i});
  assign egr_cap = tokens_of(committed_burst_bytes_q);
  // Shaper cost follows the frame at the head of the chosen queue
  assign egr_cost = tokens_of({10'h0, head_len});

  // Ingress policer
  qcs_token_bucket u_ing_bucket (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .en_i(ing_en_q),
    .rate_i(ing_rate_q),
    .cap_i(ing_cap),
    .cost_i(ing_cost),
    .take_i(in_valid_i),
    .ok_o(ing_ok)
  );

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      in_drop_o <= 1'b0;
      enq_valid_o <= 1'b0;
      enq_queue_o <= 2'd0;
      enq_len_o <= 14'd0;
      drops_q <= 16'h0;
    end else if (ce_i) begin
      in_drop_o <= in_valid_i && !ing_ok;
      enq_valid_o <= in_valid_i && ing_ok;
      if (in_valid_i) begin
        enq_queue_o <= queue;
        enq_len_o <= in_len_i;
      end
      // Counter clear loses to a drop in the same cycle, except when the count is saturated at 16'hffff
      // Saturates rather than wrapping so software never sees a false low
      if (in_valid_i && !ing_ok && drops_q != `QCS_DROP_MAX)
        drops_q <= drops_q + 16'h1;
      else if (wr_drops)
        drops_q <= 16'h0;
    end
  end

  // Egress shaping and scheduling
  assign egr_rate = (committed_rate_q < line_rate_q) ? committed_rate_q : line_rate_q;
  assign head_len = q_head_len_i[{sel_q, 4'h0} - {sel_q, 1'b0} +: 14];

  qcs_wrr_sched u_sched (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .nonempty_i(q_nonempty_i),
    .grant_i(grant),
    .sel_valid_o(sel_valid),
    .sel_q_o(sel_q)
  );

  qcs_token_bucket u_egr_bucket (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .en_i(egr_en_q),
    .rate_i(egr_rate),
    .cap_i(egr_cap),
    .cost_i(egr_cost),
    .take_i(grant),
    .ok_o(egr_ok)
  );

  // One idle cycle after each grant lets the queue status catch up
  assign grant = tx_ready_i && sel_valid && egr_ok && !deq_valid_o;

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      deq_valid_o <= 1'b0;
      deq_queue_o <= 2'd0;
    end else if (ce_i) begin
      deq_valid_o <= grant;
      if (grant)
        deq_queue_o <= sel_q;
    end
  end

  // Register read path; unmapped addresses read zero
  always @* begin
    rd_val = 32'h0;
    case (reg_addr_i)
      `QCS_A_CTRL: begin
        rd_val[`QCS_C_QOS_EN] = qos_global_enable_q;
        rd_val[`QCS_C_TRUST_DSCP] = trust_dscp_q;
        rd_val[`QCS_C_ING_EN] = ing_en_q;
        rd_val[`QCS_C_EGR_EN] = egr_en_q;
      end
      `QCS_A_DEFPRI: rd_val[2:0] = port_default_priority_q;
      `QCS_A_ING_RATE: rd_val[29:0] = ing_rate_q;
      `QCS_A_COMMITTED_RATE: rd_val[29:0] = committed_rate_q;
      `QCS_A_BURST: rd_val[23:0] = committed_burst_bytes_q;
      `QCS_A_LINE_RATE: rd_val[29:0] = line_rate_q;
      `QCS_A_STATUS: begin
        rd_val[`QCS_S_REJECT] = reject_q;
        rd_val[`QCS_S_ING_OK] = ing_ok;
        rd_val[`QCS_S_EGR_OK] = egr_ok;
      end
      `QCS_A_DROPS: rd_val[15:0] = drops_q;
      `QCS_A_PRI_MAP: rd_val[15:0] = pri_map_q;
      `QCS_A_DSCP_MAP: begin
        rd_val[5:0] = dscp_idx_q;
        rd_val[`QCS_F_QUEUE_HI:`QCS_F_QUEUE_LO] = dscp_map_q[{dscp_idx_q, 1'b0} +: 2];
      end
      default: rd_val = 32'h0;
    endcase
  end

  always @(posedge clk_i) begin
    if (!rst_b_i)
      reg_rdata_o <= 32'h0;
    else if (ce_i)
      reg_rdata_o <= reg_rd_i ? rd_val : 32'h0;
  end
endmodule

// >>> rtl/qcs_wrr_sched.v
// Strict top queue plus weighted round robin over the three lower queues
`timescale 1ns/1ns
`include "qcs_consts.vh"
module qcs_wrr_sched (
  input wire clk_i,
  input wire rst_b_i,
  input wire ce_i,
  input wire [3:0] nonempty_i,
  input wire grant_i,
  output reg sel_valid_o,
  output reg [1:0] sel_q_o
);
  reg [1:0] ptr_q;
  reg [3:0] cnt_q;

  function [1:0] nxt3;
    input [1:0] q;
    nxt3 = (q == 2'd2) ? 2'd0 : q + 2'd1;
  endfunction

  function [3:0] weight;
    input [1:0] q;
    weight = (q == 2'd0) ? `QCS_W_Q1 : (q == 2'd1) ? `QCS_W_Q2 : `QCS_W_Q3;
  endfunction

  always @* begin
    sel_valid_o = |nonempty_i;
    if (nonempty_i[`QCS_Q_STRICT])
      sel_q_o = `QCS_Q_STRICT;
    else if (nonempty_i[ptr_q])
      sel_q_o = ptr_q;
    else if (nonempty_i[nxt3(ptr_q)])
      sel_q_o = nxt3(ptr_q);
    else
      sel_q_o = nxt3(nxt3(ptr_q));
  end

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      ptr_q <= 2'd0;
      cnt_q <= 4'd0;
    end else if (ce_i && grant_i && sel_q_o != `QCS_Q_STRICT) begin
      // Turn moves on once the queue has used its weight or ran dry
      if (sel_q_o == ptr_q && cnt_q + 4'd1 < weight(sel_q_o)) begin
        cnt_q <= cnt_q + 4'd1;
      end else if (sel_q_o != ptr_q && weight(sel_q_o) > 4'd1) begin
        ptr_q <= sel_q_o;
        cnt_q <= 4'd1;
      end else begin
        ptr_q <= nxt3(sel_q_o);
        cnt_q <= 4'd0;
      end
    end
  end
endmodule

// >>> test/qcs_props.sv
// Port-level checker for the read port, policer and scheduler
`timescale 1ns/1ns
module qcs_props (
  input wire clk_i,
  input wire rst_b_i,
  input wire ce_i,
  input wire reg_rd_i,
  input wire [31:0] reg_rdata_o,
  input wire in_valid_i,
  input wire [13:0] in_len_i,
  input wire in_drop_o,
  input wire enq_valid_o,
  input wire [13:0] enq_len_o,
  input wire [3:0] q_nonempty_i,
  input wire tx_ready_i,
  input wire deq_valid_o,
  input wire [1:0] deq_queue_o
);
  default clocking cb @(posedge clk_i); endclocking
  // Frozen cycles prove nothing about timing
  default disable iff (!rst_b_i || !ce_i);
  rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data outside its slot");
  ingress_answer_a: assert property (in_valid_i |=> enq_valid_o != in_drop_o)
    else $error("frame neither queued nor dropped once");
  ingress_quiet_a: assert property (!in_valid_i |=> !enq_valid_o && !in_drop_o)
    else $error("ingress answer without a frame");
  len_copy_a: assert property (in_valid_i ##1 enq_valid_o |-> enq_len_o == $past(in_len_i))
    else $error("queued length differs");
  strict_first_a: assert property (deq_valid_o && $past(q_nonempty_i[3]) |-> deq_queue_o == 2'd3)
    else $error("lower queue served before the top queue");
  deq_gap_a: assert property (deq_valid_o |=> !deq_valid_o)
    else $error("grants closer than two cycles");
  deq_cause_a: assert property (deq_valid_o |->
    $past(tx_ready_i) && (($past(q_nonempty_i) >> deq_queue_o) & 4'h1) == 4'h1)
    else $error("grant without ready port or frame");
  deq_hold_a: assert property (!deq_valid_o |-> $stable(deq_queue_o))
    else $error("grant queue moved without a grant");
  cover property (in_drop_o);
  cover property (deq_valid_o && deq_queue_o == 2'd3);
  cover property (deq_valid_o && deq_queue_o == 2'd0);
endmodule
bind qcs_top qcs_props chk_u (.clk_i, .rst_b_i, .ce_i, .reg_rd_i, .reg_rdata_o, .in_valid_i, .in_len_i,
  .in_drop_o, .enq_valid_o, .enq_len_o, .q_nonempty_i, .tx_ready_i, .deq_valid_o, .deq_queue_o);

// >>> test/qcs_queue_model.sv
// Egress queue occupancy model on the far side of the port
`timescale 1ns/1ns
module qcs_queue_model (
  input wire clk_i,
  input wire rst_b_i,
  input wire enq_i,
  input wire [1:0] enq_q_i,
  input wire deq_i,
  input wire [1:0] deq_q_i,
  output logic [3:0] nonempty_o,
  output logic [55:0] head_len_o
);
  logic [7:0] cnt_q [4];
  // Registered, so occupancy drops in the cycle after a grant
  always @(posedge clk_i) begin
    for (int k = 0; k < 4; k++) begin
      if (!rst_b_i)
        cnt_q[k] <= 8'h0;
      else
        cnt_q[k] <= cnt_q[k] + 8'(enq_i && enq_q_i == k) - 8'(deq_i && deq_q_i == k);
    end
  end
  // Empty queue shows junk length so a design trusting it is caught
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      nonempty_o[k] = cnt_q[k] != 8'h0;
      head_len_o[14*k +: 14] = nonempty_o[k] ? 14'h40 : 14'h3fbf;
    end
  end
endmodule

// >>> test/qcs_top_tb_top.sv
// Register, classification, policing and scheduling tests for the port block
`timescale 1ns/1ns
module qcs_top_tb_top;
  logic clk_i = 1'b0, rst_b_i = 1'b0, ce_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic in_valid_i = 1'b0, in_tagged_i = 1'b0, in_has_dscp_i = 1'b0, tx_ready_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic [2:0] in_vlan_priority_value_i = 3'h0;
  logic [5:0] in_dscp_i = 6'h0;
  logic [13:0] in_len_i = 14'h40;
  wire [31:0] reg_rdata_o;
  wire in_drop_o, enq_valid_o, deq_valid_o;
  wire [1:0] enq_queue_o, deq_queue_o;
  wire [13:0] enq_len_o;
  wire [3:0] q_nonempty_i;
  wire [55:0] q_head_len_i;
  int err_total = 0, total_checks = 0, lo_n = 0, g_n = 0, n0 = 0;
  int lo_c [3] = '{0, 0, 0};
  bit mon_on = 1'b0;
  always #5 clk_i = ~clk_i;
  qcs_top dut_u (.clk_i, .rst_b_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .in_valid_i, .in_tagged_i, .in_vlan_priority_value_i, .in_has_dscp_i, .in_dscp_i, .in_len_i, .in_drop_o,
    .enq_valid_o, .enq_queue_o, .enq_len_o, .q_nonempty_i, .q_head_len_i, .tx_ready_i, .deq_valid_o,
    .deq_queue_o);
  qcs_queue_model mdl_u (.clk_i, .rst_b_i, .enq_i(enq_valid_o), .enq_q_i(enq_queue_o), .deq_i(deq_valid_o),
    .deq_q_i(deq_queue_o), .nonempty_o(q_nonempty_i), .head_len_o(q_head_len_i));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o & m, e);
  endtask
  // Outcome 0 queued, 1 dropped, 2 not judged
  task fr(input logic t, input logic [2:0] p, input logic h, input logic [5:0] d, input logic [1:0] q,
    input logic [1:0] dr);
    @(posedge clk_i);
    in_valid_i <= 1'b1;
    in_tagged_i <= t;
    in_vlan_priority_value_i <= p;
    in_has_dscp_i <= h;
    in_dscp_i <= d;
    @(posedge clk_i);
    in_valid_i <= 1'b0;
    #1;
    if (dr == 2'd1) chk({in_drop_o, enq_valid_o}, 32'h2);
    else if (dr == 2'd0) chk({in_drop_o, enq_valid_o, enq_queue_o}, {2'b01, q});
  endtask
  task results;
    $display("checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk_i) begin
    if (deq_valid_o) g_n++;
    if (mon_on && deq_valid_o && deq_queue_o != 2'd3 && lo_n < 13) begin
      lo_c[deq_queue_o]++;
      lo_n++;
    end
  end
  initial begin
    #100000;
    err_total++;
    results();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h20, 32'hfa50);
    rd(8'h08, 32'hf4240);
    rd(8'h0c, 32'h3b9aca00);
    rd(8'h14, 32'hf4240);
    rd(8'h1c, 32'h0);
    rd(8'h30, 32'h0);
    $display("test reset_values finished");
    fr(1'b1, 3'd7, 1'b0, 6'h0, 2'd0, 2'd0);
    wr(8'h00, 32'h1);
    for (int p = 0; p < 8; p++) fr(1'b1, p[2:0], 1'b0, 6'h0, p[2:1], 2'd0);
    wr(8'h04, 32'h5);
    fr(1'b0, 3'd0, 1'b0, 6'h0, 2'd2, 2'd0);
    wr(8'h04, 32'h7);
    fr(1'b0, 3'd0, 1'b0, 6'h0, 2'd3, 2'd0);
    $display("test classify finished");
    wr(8'h20, 32'h305);
    rd(8'h18, 32'h1, 32'h1);
    rd(8'h20, 32'hfa50);
    wr(8'h18, 32'h1);
    wr(8'h20, 32'h6);
    wr(8'h20, 32'h201);
    rd(8'h20, 32'hca58);
    rd(8'h18, 32'h0, 32'h1);
    fr(1'b1, 3'd1, 1'b0, 6'h0, 2'd2, 2'd0);
    fr(1'b1, 3'd6, 1'b0, 6'h0, 2'd0, 2'd0);
    wr(8'h00, 32'h101);
    rd(8'h20, 32'hfa50);
    $display("test priority_map finished");
    wr(8'h00, 32'h3);
    fr(1'b1, 3'd0, 1'b1, 6'h3f, 2'd3, 2'd0);
    fr(1'b1, 3'd7, 1'b0, 6'h0, 2'd0, 2'd0);
    wr(8'h24, 32'h303);
    rd(8'h24, 32'h303);
    fr(1'b0, 3'd0, 1'b1, 6'h3, 2'd3, 2'd0);
    wr(8'h00, 32'h203);
    fr(1'b0, 3'd0, 1'b1, 6'h3, 2'd0, 2'd0);
    $display("test dscp finished");
    wr(8'h00, 32'h5);
    wr(8'h08, 32'h64);
    rd(8'h08, 32'hdac);
    in_len_i <= 14'h1000;
    fr(1'b1, 3'd0, 1'b0, 6'h0, 2'd0, 2'd2);
    in_len_i <= 14'h40;
    fr(1'b1, 3'd0, 1'b0, 6'h0, 2'd0, 2'd1);
    wr(8'h1c, 32'h0);
    rd(8'h1c, 32'h0);
    wr(8'h08, 32'h1e8480);
    rd(8'h08, 32'hf4240);
    repeat (60) @(posedge clk_i);
    fr(1'b1, 3'd0, 1'b0, 6'h0, 2'd0, 2'd0);
    fr(1'b1, 3'd0, 1'b0, 6'h0, 2'd0, 2'd1);
    rd(8'h1c, 32'h1);
    $display("test policer finished");
    wr(8'h00, 32'h1);
    for (int i = 0; i < 13; i++) begin
      fr(1'b1, 3'd0, 1'b0, 6'h0, 2'd0, 2'd0);
      fr(1'b1, 3'd2, 1'b0, 6'h0, 2'd1, 2'd0);
      fr(1'b1, 3'd4, 1'b0, 6'h0, 2'd2, 2'd0);
    end
    mon_on <= 1'b1;
    tx_ready_i <= 1'b1;
    for (int w = 0; w < 500 && lo_n < 13; w++) @(posedge clk_i);
    tx_ready_i <= 1'b0;
    chk(lo_c[0], 32'd1);
    chk(lo_c[1], 32'd2);
    chk(lo_c[2], 32'd10);
    $display("test scheduler finished");
    wr(8'h0c, 32'ha);
    rd(8'h0c, 32'h40);
    wr(8'h10, 32'hffffff);
    rd(8'h10, 32'hffdffc);
    wr(8'h10, 32'h1);
    rd(8'h10, 32'h1000);
    wr(8'h00, 32'h9);
    tx_ready_i <= 1'b1;
    // Burst covers 64 short frames; feed more than that so the bucket runs dry
    for (int i = 0; i < 80; i++) fr(1'b1, 3'd4, 1'b0, 6'h0, 2'd2, 2'd0);
    repeat (200) @(posedge clk_i);
    tx_ready_i <= 1'b0;
    for (int i = 0; i < 10; i++) fr(1'b1, 3'd4, 1'b0, 6'h0, 2'd2, 2'd0);
    n0 = g_n;
    tx_ready_i <= 1'b1;
    repeat (200) @(posedge clk_i);
    chk(g_n - n0, 32'd0);
    wr(8'h0c, 32'h3b9aca00);
    n0 = g_n;
    repeat (300) @(posedge clk_i);
    chk(g_n - n0 >= 4 && g_n - n0 <= 6, 32'd1);
    tx_ready_i <= 1'b0;
    $display("test shaper finished");
    results();
  end
endmodule
